//--- inc/p5m_pkg.sv
package p5m_pkg;
	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_MODE_LOW = 8'hFA;
	localparam logic [7:0] IDX_MODE_HIGH = 8'hF9;
	localparam logic [7:0] IDX_DATA = 8'hF8;
	localparam logic [7:0] IDX_PIN_LEVEL = 8'hF7;
	localparam int ADDR_W = 10;
	localparam logic [1:0] WORD_LSB = 2'h0;

	// ----------------------------------------------------------------
	// Reset values and field layout
	// ----------------------------------------------------------------
	localparam logic [7:0] MODE_LOW_RESET = 8'h00;
	localparam logic [7:0] MODE_HIGH_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam int PIN_COUNT = 8;
	localparam int PINS_PER_REG = 4;
	localparam int FIELD_W = 2;

	// ----------------------------------------------------------------
	// Pin modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_INPUT = 2'h0,
		MODE_OPEN_DRAIN = 2'h1,
		MODE_PUSH_PULL = 2'h2,
		MODE_SEGMENT = 2'h3
	} p5m_mode_t;

	// ----------------------------------------------------------------
	// Bus answer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BUS_IDLE = 2'h1,
		BUS_ACK = 2'h2
	} p5m_bus_t;

	typedef struct packed {
		logic [7:0] modeLow;
		logic [7:0] modeHigh;
		logic [7:0] data;
		p5m_bus_t bus;
		logic waitReq;
		logic [31:0] readData;
		logic [7:0] pinOut;
		logic [7:0] pinOe;
		logic [7:0] segSel;
	} p5m_state_t;
endpackage

//--- hdl/p5m_port5_mode.sv
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ns
// Behaviour
// - Each pin has a 2-bit mode field, pins 3..0 in the low register and pins 7..4 in the high one, 00 input, 01 open-drain, 10 push-pull, 11 segment.
// - Mode 11 cuts the port output path off the pin and hands the pin to its LCD segment driver.
// - Open-drain mode pulls the pin low for a stored 0 and leaves it undriven for a stored 1.
// - The mode registers answer only to direct register accesses; indirect accesses do not reach them.
module p5m_port5_mode (
	input wire logic mclk, // System clock, 20 MHz
	input wire logic rst_b, // Asynchronous reset, active low
	input wire logic [9:0] avsAddress, // Avalon byte address
	input wire logic avsRead, // Avalon read request
	input wire logic avsWrite, // Avalon write request
	input wire logic [31:0] avsWriteData, // Avalon write data
	input wire logic [3:0] avsByteEnable, // Avalon byte enables
	input wire logic avsIndirect, // High when the access uses an indirect form
	output logic [31:0] avsReadData, // Avalon read data
	output logic avsWaitRequest, // Avalon wait request
	input wire logic [7:0] pinIn, // Pad input levels, pin 0 in bit 0
	output logic [7:0] pinOut, // Pad output levels
	output logic [7:0] pinOe, // Pad output enables, high while driving
	output logic [7:0] segSel // High where the segment driver owns the pad
);

	p5m_pkg::p5m_state_t stateReg;
	p5m_pkg::p5m_state_t stateNext;

	// Bit positions in the one-hot register select
	localparam int SEL_MODE_LOW = 0;
	localparam int SEL_MODE_HIGH = 1;
	localparam int SEL_DATA = 2;
	localparam int SEL_PIN_LEVEL = 3;
	localparam int SEL_W = 4;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [1:0] pinMode(input logic [7:0] lo, input logic [7:0] hi, input int idx);
		logic [15:0] both;
		both = {hi, lo};
		pinMode = both[idx * p5m_pkg::FIELD_W +: p5m_pkg::FIELD_W];
	endfunction

	function automatic logic [7:0] byteWrite(input logic [7:0] old, input logic [31:0] wd, input logic en);
		byteWrite = en ? wd[7:0] : old;
	endfunction

	// One-hot register select, shared by the read mux and the write strobe
	function automatic logic [SEL_W-1:0] regSelect(input logic [7:0] idx, input logic hit);
		regSelect = {SEL_W{1'b0}};
		if (hit) begin
			case (idx)
				p5m_pkg::IDX_MODE_LOW: begin
					regSelect[SEL_MODE_LOW] = 1'b1;
				end
				p5m_pkg::IDX_MODE_HIGH: begin
					regSelect[SEL_MODE_HIGH] = 1'b1;
				end
				p5m_pkg::IDX_DATA: begin
					regSelect[SEL_DATA] = 1'b1;
				end
				p5m_pkg::IDX_PIN_LEVEL: begin
					regSelect[SEL_PIN_LEVEL] = 1'b1;
				end
				default: begin
					regSelect = {SEL_W{1'b0}};
				end
			endcase
		end
	endfunction

	// Pad controls of one pin as {drive level, output enable, segment select}
	function automatic logic [2:0] padDrive(input logic [1:0] modeCode, input logic level);
		padDrive = 3'h0;
		case (modeCode)
			p5m_pkg::MODE_INPUT: begin
				padDrive = 3'h0;
			end
			p5m_pkg::MODE_OPEN_DRAIN: begin
				// Only the low level is ever driven, so a stored 1 floats
				padDrive = {1'b0, ~level, 1'b0};
			end
			p5m_pkg::MODE_PUSH_PULL: begin
				padDrive = {level, 1'b1, 1'b0};
			end
			p5m_pkg::MODE_SEGMENT: begin
				// Port drive is cut so it never fights the segment driver
				padDrive = 3'h1;
			end
			default: begin
				padDrive = 3'h0;
			end
		endcase
	endfunction

	logic reqActive;
	logic [7:0] regIndex;
	logic aligned;
	logic directHit;

	assign reqActive = avsRead | avsWrite;
	assign regIndex = avsAddress[9:2];
	assign aligned = (avsAddress[1:0] == p5m_pkg::WORD_LSB);
	// Indirect forms never decode, so they read zero and write nothing
	assign directHit = aligned & ~avsIndirect;

	logic [SEL_W-1:0] regSel;
	logic [7:0] padOutNext;
	logic [7:0] padOeNext;
	logic [7:0] padSegNext;

	assign regSel = regSelect(regIndex, directHit);

	// ----------------------------------------------------------------
	// Pad decode, one slice per pin
	// ----------------------------------------------------------------
	// Decoded from the registered modes, so the pads lag a mode write by one cycle
	generate
		for (genvar g = 0; g < p5m_pkg::PIN_COUNT; g++) begin : g_pad
			logic [1:0] modeCode;
			assign modeCode = pinMode(stateReg.modeLow, stateReg.modeHigh, g);
			assign {padOutNext[g], padOeNext[g], padSegNext[g]} = padDrive(modeCode, stateReg.data[g]);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic doWrite;
		doWrite = (stateReg.bus == p5m_pkg::BUS_ACK) & avsWrite & directHit;
		stateNext = stateReg;

		// One wait cycle; the answer stands for the single cycle it is taken
		case (stateReg.bus)
			p5m_pkg::BUS_IDLE: begin
				if (reqActive) begin
					stateNext.bus = p5m_pkg::BUS_ACK;
					stateNext.waitReq = 1'b0;
				end
			end
			p5m_pkg::BUS_ACK: begin
				stateNext.bus = p5m_pkg::BUS_IDLE;
				stateNext.waitReq = 1'b1;
			end
			default: begin
				stateNext.bus = p5m_pkg::BUS_IDLE;
				stateNext.waitReq = 1'b1;
			end
		endcase

		// Read data is prepared during the wait cycle; unmapped and indirect reads give zero
		stateNext.readData = 32'h0000_0000;
		if (avsRead) begin
			if (regSel[SEL_MODE_LOW]) begin
				stateNext.readData[7:0] = stateReg.modeLow;
			end
			if (regSel[SEL_MODE_HIGH]) begin
				stateNext.readData[7:0] = stateReg.modeHigh;
			end
			if (regSel[SEL_DATA]) begin
				stateNext.readData[7:0] = stateReg.data;
			end
			if (regSel[SEL_PIN_LEVEL]) begin
				stateNext.readData[7:0] = pinIn;
			end
		end

		// The write lands at the edge where the master sees waitrequest low
		if (doWrite) begin
			if (regSel[SEL_MODE_LOW]) begin
				stateNext.modeLow = byteWrite(stateReg.modeLow, avsWriteData, avsByteEnable[0]);
			end
			if (regSel[SEL_MODE_HIGH]) begin
				stateNext.modeHigh = byteWrite(stateReg.modeHigh, avsWriteData, avsByteEnable[0]);
			end
			// The pin level register is read-only, so a write to it is dropped
			if (regSel[SEL_DATA]) begin
				stateNext.data = byteWrite(stateReg.data, avsWriteData, avsByteEnable[0]);
			end
		end

		// Pad drive follows the stored modes one cycle after a write lands
		stateNext.pinOut = padOutNext;
		stateNext.pinOe = padOeNext;
		stateNext.segSel = padSegNext;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			stateReg.modeLow <= p5m_pkg::MODE_LOW_RESET;
			stateReg.modeHigh <= p5m_pkg::MODE_HIGH_RESET;
			stateReg.data <= p5m_pkg::DATA_RESET;
			stateReg.bus <= p5m_pkg::BUS_IDLE;
			stateReg.waitReq <= 1'b1;
			stateReg.readData <= 32'h0000_0000;
			stateReg.pinOut <= 8'h00;
			stateReg.pinOe <= 8'h00;
			stateReg.segSel <= 8'h00;
		end else begin
			stateReg <= stateNext;
		end
	end

	assign avsReadData = stateReg.readData;
	assign avsWaitRequest = stateReg.waitReq;
	assign pinOut = stateReg.pinOut;
	assign pinOe = stateReg.pinOe;
	assign segSel = stateReg.segSel;

endmodule

//--- dv/p5m_port5_mode_checker.sv
`timescale 1ns/1ns
module p5m_port5_mode_checker (
	input wire logic mclk, // System clock
	input wire logic rst_b, // Asynchronous reset, active low
	input wire logic [9:0] avsAddress, // Byte address
	input wire logic avsRead, // Read request
	input wire logic avsWrite, // Write request
	input wire logic [31:0] avsWriteData, // Write data
	input wire logic [3:0] avsByteEnable, // Byte enables
	input wire logic avsIndirect, // Indirect access marker
	input wire logic [31:0] avsReadData, // Read data
	input wire logic avsWaitRequest, // Wait request
	input wire logic [7:0] pinIn, // Pad levels
	input wire logic [7:0] pinOut, // Pad drive levels
	input wire logic [7:0] pinOe, // Pad output enables
	input wire logic [7:0] segSel // Segment driver owns the pad
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_answer_next_cycle: assert property ((avsRead || avsWrite) && avsWaitRequest |-> ##1 !avsWaitRequest)
		else $error("request not answered in one cycle");
	a_wait_low_once: assert property (!avsWaitRequest |=> avsWaitRequest) else $error("waitrequest low twice");
	a_indirect_read_zero: assert property (avsRead && avsIndirect && !avsWaitRequest |-> avsReadData == 32'h0)
		else $error("indirect read returned data");
	a_indirect_write_void: assert property (avsWrite && avsIndirect && !avsWaitRequest |=> ##1 $stable({pinOe, pinOut, segSel}))
		else $error("indirect write changed pads");
	a_segment_not_driven: assert property ((segSel & pinOe) == 8'h0) else $error("segment pad still driven");
	a_start_as_input: assert property ($rose(rst_b) |-> pinOe == 8'h0 && segSel == 8'h0) else $error("pads not inputs");
	a_level_needs_drive: assert property ((pinOut & ~pinOe) == 8'h0) else $error("drive level on undriven pad");
endmodule

//--- dv/p5m_port5_mode_tb_top.sv
`timescale 1ns/1ns
module p5m_port5_mode_tb_top;
	logic mclk = 1'b0, rst_b = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, avsIndirect = 1'b0, avsWaitRequest;
	logic [9:0] avsAddress = 10'h0;
	logic [31:0] avsWriteData = 32'h0, avsReadData, rd;
	logic [3:0] avsByteEnable = 4'h1;
	logic [7:0] pinIn = 8'h0, pinOut, pinOe, segSel, lo, hi, dat;
	int mismatches = 0, checks = 0;
	always #25 mclk = ~mclk;
	p5m_port5_mode DUT (
		.mclk(mclk),
		.rst_b(rst_b),
		.avsAddress(avsAddress),
		.avsRead(avsRead),
		.avsWrite(avsWrite),
		.avsWriteData(avsWriteData),
		.avsByteEnable(avsByteEnable),
		.avsIndirect(avsIndirect),
		.avsReadData(avsReadData),
		.avsWaitRequest(avsWaitRequest),
		.pinIn(pinIn),
		.pinOut(pinOut),
		.pinOe(pinOe),
		.segSel(segSel)
	);
	task automatic chk(input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Request starts one edge after the last release, so no signal is assigned twice in a step
	// Only the watchdog ends a wait that never gets its answer
	task automatic acc(input logic wr, ind, input logic [7:0] idx, d);
		@(posedge mclk);
		avsRead <= !wr;
		avsWrite <= wr;
		avsIndirect <= ind;
		avsAddress <= {idx, 2'h0};
		avsWriteData <= {24'h0, d};
		do begin
			@(posedge mclk);
		end while (avsWaitRequest !== 1'b0);
		rd = avsReadData;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
	endtask
	function automatic logic [23:0] pads(input logic [15:0] m, input logic [7:0] d);
		pads = 24'h0;
		for (int i = 0; i < 8; i++) begin
			case (m[2*i+:2])
				2'h1: pads[8+i] = !d[i];
				2'h2: {pads[16+i], pads[8+i]} = {d[i], 1'b1};
				2'h3: pads[i] = 1'b1;
				default: ;
			endcase
		end
	endfunction
	task automatic conclude;
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// About five times the length of a clean run
	initial begin
		#300000;
		mismatches++;
		conclude();
	end
	initial begin
		void'($urandom(81));
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		for (int k = 0; k < 42; k++) begin
			// First four passes put every pin in the same mode, one code each
			lo = (k < 4) ? {4{k[1:0]}} : 8'($urandom);
			hi = (k < 4) ? {4{k[1:0]}} : 8'($urandom);
			dat = 8'($urandom);
			pinIn <= 8'($urandom);
			if (k == 0) begin
				acc(0, 0, p5m_pkg::IDX_MODE_HIGH, 8'h0);
				chk(rd, 32'h0);
			end
			acc(1, 0, p5m_pkg::IDX_MODE_LOW, lo);
			acc(1, 0, p5m_pkg::IDX_MODE_HIGH, hi);
			acc(1, 0, p5m_pkg::IDX_DATA, dat);
			acc(1, 1, p5m_pkg::IDX_MODE_LOW, ~lo);
			// Lane 0 disabled: the write is answered but leaves the register alone
			avsByteEnable <= {3'($urandom), 1'b0};
			acc(1, 0, p5m_pkg::IDX_MODE_HIGH, ~hi);
			avsByteEnable <= {3'($urandom), 1'b1};
			acc(0, 0, p5m_pkg::IDX_MODE_LOW, 8'h0);
			chk(rd, {24'h0, lo});
			acc(0, 1, p5m_pkg::IDX_MODE_HIGH, 8'h0);
			chk(rd, 32'h0);
			acc(0, 0, p5m_pkg::IDX_MODE_HIGH, 8'h0);
			chk(rd, {24'h0, hi});
			acc(0, 0, p5m_pkg::IDX_DATA, 8'h0);
			chk(rd, {24'h0, dat});
			acc(0, 0, p5m_pkg::IDX_PIN_LEVEL, 8'h0);
			chk(rd, {24'h0, pinIn});
			chk(32'({pinOut, pinOe, segSel}), 32'(pads({hi, lo}, dat)));
		end
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		chk(32'({pinOut, pinOe, segSel}), 32'h0);
		acc(0, 0, p5m_pkg::IDX_MODE_LOW, 8'h0);
		chk(rd, 32'h0);
		acc(0, 0, p5m_pkg::IDX_MODE_HIGH, 8'h0);
		chk(rd, 32'h0);
		conclude();
	end
endmodule
bind p5m_port5_mode p5m_port5_mode_checker mon (
	.mclk(mclk),
	.rst_b(rst_b),
	.avsAddress(avsAddress),
	.avsRead(avsRead),
	.avsWrite(avsWrite),
	.avsWriteData(avsWriteData),
	.avsByteEnable(avsByteEnable),
	.avsIndirect(avsIndirect),
	.avsReadData(avsReadData),
	.avsWaitRequest(avsWaitRequest),
	.pinIn(pinIn),
	.pinOut(pinOut),
	.pinOe(pinOe),
	.segSel(segSel)
);
